/* File: hw/rfa_addr_filter.sv */
/*
 * rfa_addr_filter: address building, receive filtering and assured
 * delivery for a packet radio. Registers over apb; packet headers arrive
 * from the radio core already decoded, payload moves elsewhere.
 * Assumes rx_valid pulses are at least two cycles apart and that the
 * radio core only pulses rx_valid for packets that passed their checks.
 */
// Functional notes
// - addressing mode register writable any time; tx uses current value
// - receiver evaluates serial, user and extended packets in every mode
// - matching packets forwarded to host, others dropped silently
// - mode codes 0x04 serial, 0x06 user, 0x07 extended user
// - acknowledged variants 0x14, 0x16, 0x17
// - serial mode: own serial as source, target serial as destination
// - serial mode: only receiver with equal serial outputs payload
// - user mode sends customer code unencrypted and 16-bit destination
// - mask splits address into fields for broadcast and unicast
// - ack only on exact local identifier match, mask ignored
// - extended user mode uses full 32-bit identifiers and mask
// - compatibility 0x03 matches leading-zero mask bits only
// - relaxed 0x00 uses 16-bit identifier and mask, normal 32-bit; code applies 16-bit to user packets only, extended stay 32-bit
// - auto addressing copies valid sender address into destination
// - transmitter waits rate-dependent ack period then retransmits
// - duplicates are acknowledged but their payload dropped
// - acknowledgement sent immediately with no backoff
// - ack completes block; buffer empty high when queue empty
// - retransmit until retry limit used up
// - retries exhausted raise the exception line
// - bit 4 of mode register requests acknowledgements
module rfa_addr_filter #(
  parameter logic [31:0] OWN_SERIAL   = 32'h1357_9bdf, // arbitrary value
  parameter logic [15:0] CUST_CODE    = 16'h0a5c,      // arbitrary value
  parameter int          ACK_WAIT_CYC = rfa_pkg::ACK_WAIT_CYC
) (
  input  wire logic                     clock,
  input  wire logic                     rstn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     rx_valid,
  input  wire logic [2:0]               rx_type,
  input  wire logic                     rx_ack_req,
  input  wire logic                     rx_is_ack,
  input  wire logic [31:0]              rx_src,
  input  wire logic [31:0]              rx_dst,
  input  wire logic [rfa_pkg::SEQ_W-1:0] rx_seq,
  output logic                          rx_forward,
  output logic                          rx_discard,
  output logic                          ack_send,
  output logic                          ack_skip_backoff,
  output logic      [2:0]               ack_type,
  output logic      [31:0]              ack_dst,
  output logic      [rfa_pkg::SEQ_W-1:0] ack_seq,
  input  wire logic                     tx_request,
  input  wire logic                     tx_queue_empty,
  input  wire logic                     tx_accept,
  output logic                          tx_go,
  output logic      [2:0]               tx_type,
  output logic                          tx_ack_req,
  output logic      [31:0]              tx_src,
  output logic      [31:0]              tx_dst,
  output logic                          tx_cust_en,
  output logic      [15:0]              tx_cust,
  output logic      [rfa_pkg::SEQ_W-1:0] tx_seq,
  output logic                          buffer_empty_line,
  output logic                          exception_line
);

  localparam int SW = rfa_pkg::SEQ_W;
  localparam int IW = rfa_pkg::SEEN_IDX_W;

  // software-visible configuration
  logic [7:0]  addr_mode;
  logic [7:0]  compatibility_select;
  logic [2:0]  auto_addr;
  logic [31:0] target_serial;
  logic [31:0] user_target;
  logic [31:0] user_local;
  logic [31:0] user_mask;
  logic [6:0]  control;

  // transmit state
  rfa_pkg::rfa_tx_state_t tx_state;
  logic [31:0] wait_cnt;
  logic [3:0]  tries;
  logic        pending;

  // receive pipeline
  logic        rx_stage;
  logic [2:0]  st_type;
  logic        st_ack_req;
  logic [31:0] st_src;
  logic [SW-1:0] st_seq;
  logic        st_accept;
  logic        st_exact;
  logic [rfa_pkg::SEEN_W-1:0] seen_rd;

  logic wr_cycle;
  logic rd_cycle;
  logic ack_seen;
  logic wait_done;
  logic exc_clear;
  logic [31:0] wait_len;

  // leading contiguous zeros of a mask, as a contiguous run of ones
  function automatic logic [31:0] lead_zero_field(input logic [31:0] m);
    logic [31:0] f;
    logic        run;
    f   = '0;
    run = 1'b1;
    for (int i = 31; i >= 0; i--)
    begin
      run  = run & ~m[i];
      f[i] = run;
    end
    return f;
  endfunction

  // fixed bits must match; masked bits match own value or all ones
  function automatic logic masked_match(input logic [31:0] d,
                                        input logic [31:0] l,
                                        input logic [31:0] m);
    logic fixed_ok;
    logic free_ok;
    fixed_ok = ((d ^ l) & ~m) == 32'h0000_0000;
    free_ok  = ((d & m) == (l & m)) || ((d & m) == m);
    return fixed_ok && free_ok;
  endfunction

  function automatic logic [IW-1:0] slot_of(input logic [31:0] a);
    return a[IW-1:0] ^ a[2*IW-1:IW] ^ a[3*IW-1:2*IW];
  endfunction

  // apb: zero wait states, unmapped offsets answer with an error
  assign pready   = 1'b1;
  assign wr_cycle = psel && penable && pwrite;
  // reads sampled in the setup phase so data stands at the access edge
  assign rd_cycle = psel && !penable && !pwrite;

  always_comb
  begin
    pslverr = 1'b0;
    if (psel && penable)
    begin
      case (paddr)
        rfa_pkg::OFS_ADDR_MODE, rfa_pkg::OFS_COMPATIBILITY_SELECT,
        rfa_pkg::OFS_AUTO_ADDR, rfa_pkg::OFS_TARGET_SN,
        rfa_pkg::OFS_USER_TARGET, rfa_pkg::OFS_USER_LOCAL,
        rfa_pkg::OFS_USER_MASK, rfa_pkg::OFS_OWN_SN,
        rfa_pkg::OFS_CONTROL, rfa_pkg::OFS_STATUS,
        rfa_pkg::OFS_CUST_CODE: pslverr = 1'b0;
        default:                pslverr = 1'b1;
      endcase
    end
  end

  // read data registered at the setup edge; status may lag by one cycle
  always_ff @(posedge clock)
  begin
    if (!rstn)
      prdata <= 32'h0000_0000;
    else if (rd_cycle)
    begin
      case (paddr)
        rfa_pkg::OFS_ADDR_MODE:   prdata <= {24'h00_0000, addr_mode};
        rfa_pkg::OFS_COMPATIBILITY_SELECT:      prdata <= {24'h00_0000, compatibility_select};
        rfa_pkg::OFS_AUTO_ADDR:   prdata <= {29'h0, auto_addr};
        rfa_pkg::OFS_TARGET_SN:   prdata <= target_serial;
        rfa_pkg::OFS_USER_TARGET: prdata <= user_target;
        rfa_pkg::OFS_USER_LOCAL:  prdata <= user_local;
        rfa_pkg::OFS_USER_MASK:   prdata <= user_mask;
        rfa_pkg::OFS_OWN_SN:      prdata <= OWN_SERIAL;
        rfa_pkg::OFS_CONTROL:     prdata <= {25'h0, control};
        rfa_pkg::OFS_STATUS:      prdata <= {23'h0, tx_state != rfa_pkg::RFA_TX_IDLE,
                                             tries, 1'b0,
                                             tx_state != rfa_pkg::RFA_TX_IDLE,
                                             exception_line,
                                             buffer_empty_line};
        rfa_pkg::OFS_CUST_CODE:   prdata <= {16'h0000, CUST_CODE};
        default:                  prdata <= 32'h0000_0000;
      endcase
    end
  end

  // plain configuration; mode may change while traffic runs
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      addr_mode  <= rfa_pkg::RST_ADDR_MODE;
      compatibility_select     <= rfa_pkg::RST_COMPATIBILITY_SELECT;
      auto_addr  <= rfa_pkg::RST_AUTO_ADDR;
      user_local <= rfa_pkg::RST_ADDR;
      user_mask  <= rfa_pkg::RST_MASK;
      control    <= rfa_pkg::RST_CONTROL;
    end
    else if (wr_cycle)
    begin
      case (paddr)
        rfa_pkg::OFS_ADDR_MODE:  addr_mode  <= pwdata[7:0];
        rfa_pkg::OFS_COMPATIBILITY_SELECT:     compatibility_select     <= pwdata[7:0];
        rfa_pkg::OFS_AUTO_ADDR:  auto_addr  <= pwdata[2:0];
        rfa_pkg::OFS_USER_LOCAL: user_local <= pwdata;
        rfa_pkg::OFS_USER_MASK:  user_mask  <= pwdata;
        rfa_pkg::OFS_CONTROL:    control    <= pwdata[6:0];
        default:                 control    <= control;
      endcase
    end
  end

  // destination registers; a captured sender address wins over software
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      target_serial <= rfa_pkg::RST_ADDR;
      user_target   <= rfa_pkg::RST_ADDR;
    end
    else if (st_accept && !st_is_dup()
             && st_type == rfa_pkg::MODE_SERIAL
             && auto_addr[rfa_pkg::AUTO_SERIAL_BIT])
      target_serial <= st_src;
    else if (st_accept && !st_is_dup()
             && ((st_type == rfa_pkg::MODE_USER
                  && auto_addr[rfa_pkg::AUTO_USER_BIT])
              || (st_type == rfa_pkg::MODE_EXT_USER
                  && auto_addr[rfa_pkg::AUTO_EXT_BIT])))
      user_target <= st_src;
    else if (wr_cycle && paddr == rfa_pkg::OFS_TARGET_SN)
      target_serial <= pwdata;
    else if (wr_cycle && paddr == rfa_pkg::OFS_USER_TARGET)
      user_target <= pwdata;
  end

  // duplicate check against the last tag stored for this sender slot
  function automatic logic st_is_dup();
    return seen_rd[rfa_pkg::SEEN_W-1]
           && seen_rd[rfa_pkg::SEEN_W-2:SW] == st_src
           && seen_rd[SW-1:0] == st_seq;
  endfunction

  // stage 0: address decision for every packet type, whatever our mode
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      rx_stage   <= 1'b0;
      st_accept  <= 1'b0;
      st_exact   <= 1'b0;
      st_type    <= 3'h0;
      st_ack_req <= 1'b0;
      st_src     <= 32'h0000_0000;
      st_seq     <= '0;
    end
    else
    begin
      rx_stage   <= rx_valid && !rx_is_ack;
      st_type    <= rx_type;
      st_ack_req <= rx_ack_req;
      st_src     <= rx_src;
      st_seq     <= rx_seq;
      case (rx_type)
        rfa_pkg::MODE_SERIAL:
        begin
          st_accept <= rx_dst == OWN_SERIAL;
          st_exact  <= rx_dst == OWN_SERIAL;
        end
        rfa_pkg::MODE_USER, rfa_pkg::MODE_EXT_USER:
        begin
          if (compatibility_select == rfa_pkg::COMPATIBILITY_SELECT_NETWORK)
            st_accept <= ((rx_dst ^ user_local)
                          & lead_zero_field(user_mask)) == 32'h0;
          else if (rx_type == rfa_pkg::MODE_USER
                   && compatibility_select == rfa_pkg::COMPATIBILITY_SELECT_RELAXED)
            st_accept <= masked_match({16'h0000, rx_dst[15:0]},
                                      {16'h0000, user_local[15:0]},
                                      {16'h0000, user_mask[15:0]});
          else
            st_accept <= masked_match(rx_dst, user_local,
                                      user_mask);
          st_exact <= rx_dst == user_local;
        end
        default:
        begin
          st_accept <= 1'b0;
          st_exact  <= 1'b0;
        end
      endcase
    end
  end

  // stage 1: forward, drop, acknowledge
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      rx_forward       <= 1'b0;
      rx_discard       <= 1'b0;
      ack_send         <= 1'b0;
      ack_skip_backoff <= 1'b0;
      ack_type         <= 3'h0;
      ack_dst          <= 32'h0000_0000;
      ack_seq          <= '0;
    end
    else
    begin
      rx_forward <= rx_stage && st_accept && !st_is_dup();
      rx_discard <= rx_stage && !(st_accept && !st_is_dup());
      ack_send   <= rx_stage && st_ack_req && st_exact;
      ack_skip_backoff <= rx_stage && st_ack_req && st_exact;
      if (rx_stage)
      begin
        ack_type <= st_type;
        ack_dst  <= st_src;
        ack_seq  <= st_seq;
      end
    end
  end

  // tag table; entries age out only by overwrite or reset
  rfa_seen_mem #(
    .DEPTH_W (IW),
    .WIDTH   (rfa_pkg::SEEN_W)
  ) u_seen (
    .clock   (clock),
    .rstn    (rstn),
    .clear   (1'b0),
    .rd_addr (slot_of(rx_src)),
    .rd_data (seen_rd),
    .wr_en   (rx_stage && st_accept),
    .wr_addr (slot_of(st_src)),
    .wr_data ({1'b1, st_src, st_seq})
  );

  // an ack for the outstanding packet carries its sequence tag
  assign ack_seen  = rx_valid && rx_is_ack && rx_seq == tx_seq;
  assign wait_len  = 32'(ACK_WAIT_CYC)
                     << control[rfa_pkg::CTL_RATE_MSB:rfa_pkg::CTL_RATE_LSB];
  assign wait_done = wait_cnt >= wait_len - 32'd1;

  // only a request that lands while busy is remembered, else blocks repeat
  always_ff @(posedge clock)
  begin
    if (!rstn)
      pending <= 1'b0;
    else if (tx_request && tx_state != rfa_pkg::RFA_TX_IDLE)
      pending <= 1'b1;
    else if (tx_state == rfa_pkg::RFA_TX_IDLE)
      pending <= 1'b0;
  end

  // transmit sequencer: send, wait for ack, retry
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      tx_state <= rfa_pkg::RFA_TX_IDLE;
      wait_cnt <= 32'h0000_0000;
      tries    <= 4'h0;
      tx_seq   <= '0;
    end
    else
    begin
      case (tx_state)
        rfa_pkg::RFA_TX_IDLE:
          if (tx_request || pending)
          begin
            tx_state <= rfa_pkg::RFA_TX_SEND;
            tries    <= 4'h0;
            tx_seq   <= tx_seq + SW'(1); // new tag per block, not per retry
          end
        rfa_pkg::RFA_TX_SEND:
          if (tx_accept)
          begin
            wait_cnt <= 32'h0000_0000;
            if (tx_ack_req)
              tx_state <= rfa_pkg::RFA_TX_WAIT;
            else
              tx_state <= rfa_pkg::RFA_TX_IDLE;
          end
        rfa_pkg::RFA_TX_WAIT:
          if (ack_seen)
            tx_state <= rfa_pkg::RFA_TX_IDLE;
          else if (wait_done)
          begin
            wait_cnt <= 32'h0000_0000;
            if (tries < control[rfa_pkg::CTL_RETRY_MSB:
                                rfa_pkg::CTL_RETRY_LSB])
            begin
              tries    <= tries + 4'h1;
              tx_state <= rfa_pkg::RFA_TX_SEND;
            end
            else
              tx_state <= rfa_pkg::RFA_TX_IDLE;
          end
          else
            wait_cnt <= wait_cnt + 32'd1;
        default:
          tx_state <= rfa_pkg::RFA_TX_IDLE;
      endcase
    end
  end

  // header fields follow the mode register as it stands right now
  always_comb
  begin
    tx_go      = tx_state == rfa_pkg::RFA_TX_SEND;
    tx_type    = addr_mode[2:0];
    tx_ack_req = addr_mode[rfa_pkg::ACK_REQ_BIT];
    tx_cust    = CUST_CODE;
    tx_cust_en = !control[rfa_pkg::CTL_ENCRYPT_BIT];
    case (addr_mode[2:0])
      rfa_pkg::MODE_SERIAL:
      begin
        tx_src = OWN_SERIAL;
        tx_dst = target_serial;
      end
      rfa_pkg::MODE_USER:
      begin
        tx_src = {16'h0000, user_local[15:0]};
        tx_dst = {16'h0000, user_target[15:0]};
      end
      default:
      begin
        tx_src = user_local;
        tx_dst = user_target;
      end
    endcase
  end

  // exception is sticky: a new failure wins over a software clear
  assign exc_clear = wr_cycle && paddr == rfa_pkg::OFS_STATUS
                     && pwdata[rfa_pkg::STS_EXCEPT_BIT];

  always_ff @(posedge clock)
  begin
    if (!rstn)
      exception_line <= 1'b0;
    else if (tx_state == rfa_pkg::RFA_TX_WAIT && !ack_seen && wait_done
             && tries >= control[rfa_pkg::CTL_RETRY_MSB:
                                 rfa_pkg::CTL_RETRY_LSB])
      exception_line <= 1'b1;
    else if (exc_clear)
      exception_line <= 1'b0;
  end

  // empty once the last block completes and nothing else is queued
  always_ff @(posedge clock)
  begin
    if (!rstn)
      buffer_empty_line <= 1'b1;
    else
      buffer_empty_line <= tx_state == rfa_pkg::RFA_TX_IDLE
                           && !pending && !tx_request
                           && tx_queue_empty;
  end

endmodule

/* File: hw/rfa_pkg.sv */
/*
 * rfa_pkg: shared constants for the address filter and assured-delivery
 * block: register byte offsets, field positions, reset values, mode codes
 * and timing counts.
 * Assumes a single 125 MHz clock and a 32-bit apb register bus.
 */
package rfa_pkg;

  // clock rate and ack wait timing
  localparam int CLK_MHZ          = 125;
  localparam int ACK_WAIT_US      = 4000;
  localparam int ACK_WAIT_CYC     = ACK_WAIT_US * CLK_MHZ;

  // register byte offsets
  localparam logic [7:0] OFS_ADDR_MODE   = 8'h00;
  localparam logic [7:0] OFS_COMPATIBILITY_SELECT      = 8'h04;
  localparam logic [7:0] OFS_AUTO_ADDR   = 8'h08;
  localparam logic [7:0] OFS_TARGET_SN   = 8'h0c;
  localparam logic [7:0] OFS_USER_TARGET = 8'h10;
  localparam logic [7:0] OFS_USER_LOCAL  = 8'h14;
  localparam logic [7:0] OFS_USER_MASK   = 8'h18;
  localparam logic [7:0] OFS_OWN_SN      = 8'h1c;
  localparam logic [7:0] OFS_CONTROL     = 8'h20;
  localparam logic [7:0] OFS_STATUS      = 8'h24;
  localparam logic [7:0] OFS_CUST_CODE   = 8'h28;

  // addressing mode codes and the ack request flag
  localparam logic [2:0] MODE_SERIAL     = 3'h4;
  localparam logic [2:0] MODE_USER       = 3'h6;
  localparam logic [2:0] MODE_EXT_USER   = 3'h7;
  localparam int         ACK_REQ_BIT     = 4;

  // compatibility select values
  localparam logic [7:0] COMPATIBILITY_SELECT_RELAXED  = 8'h00;
  localparam logic [7:0] COMPATIBILITY_SELECT_NORMAL   = 8'h02;
  localparam logic [7:0] COMPATIBILITY_SELECT_NETWORK  = 8'h03;

  // auto reply address enable bits, one per mode
  localparam int AUTO_SERIAL_BIT   = 0;
  localparam int AUTO_USER_BIT     = 1;
  localparam int AUTO_EXT_BIT      = 2;

  // control fields
  localparam int CTL_RETRY_LSB     = 0;
  localparam int CTL_RETRY_MSB     = 3;
  localparam int CTL_RATE_LSB      = 4;
  localparam int CTL_RATE_MSB      = 5;
  localparam int CTL_ENCRYPT_BIT   = 6;

  // status fields
  localparam int STS_EMPTY_BIT     = 0;
  localparam int STS_EXCEPT_BIT    = 1;
  localparam int STS_BUSY_BIT      = 2;
  localparam int STS_TRIES_LSB     = 4;
  localparam int STS_TRIES_MSB     = 7;

  // reset values
  localparam logic [7:0]  RST_ADDR_MODE  = 8'h06;
  localparam logic [7:0]  RST_COMPATIBILITY_SELECT     = 8'h02;
  localparam logic [2:0]  RST_AUTO_ADDR  = 3'h0;
  localparam logic [31:0] RST_ADDR       = 32'h0000_0000;
  localparam logic [31:0] RST_MASK       = 32'hffff_ffff;
  localparam logic [6:0]  RST_CONTROL    = 7'h03;

  // duplicate table entry: valid, source, sequence tag
  localparam int SEQ_W             = 8;
  localparam int SEEN_IDX_W        = 4;
  localparam int SEEN_W            = 1 + 32 + SEQ_W;

  typedef enum logic [1:0] {
    RFA_TX_IDLE,
    RFA_TX_SEND,
    RFA_TX_WAIT
  } rfa_tx_state_t;

endpackage

/* File: hw/rfa_seen_mem.sv */
/*
 * rfa_seen_mem: small single-port-write, registered-read memory that holds
 * the last accepted packet tag per sender slot.
 * Assumes one clock, synchronous active-low reset clearing the read register
 * and the live vector; entries are also qualified by the valid bit the owner writes.
 */
module rfa_seen_mem #(
  parameter int DEPTH_W = 4,
  parameter int WIDTH   = 41
) (
  input  wire logic               clock,
  input  wire logic               rstn,
  input  wire logic               clear,
  input  wire logic [DEPTH_W-1:0] rd_addr,
  output logic      [WIDTH-1:0]   rd_data,
  input  wire logic               wr_en,
  input  wire logic [DEPTH_W-1:0] wr_addr,
  input  wire logic [WIDTH-1:0]   wr_data
);

  logic [WIDTH-1:0] mem [2**DEPTH_W];
  logic [2**DEPTH_W-1:0] live;

  // storage; the live vector stands in for a memory-wide clear
  always_ff @(posedge clock)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
  end

  always_ff @(posedge clock)
  begin
    if (!rstn || clear)
      live <= '0;
    else if (wr_en)
      live[wr_addr] <= 1'b1;
  end

  // read data always comes out of a register
  always_ff @(posedge clock)
  begin
    if (!rstn)
      rd_data <= '0;
    else if (live[rd_addr])
      rd_data <= mem[rd_addr];
    else
      rd_data <= '0;
  end

endmodule

/* File: tb/rfa_addr_filter_checker.sv */
/* checker for rfa_addr_filter port timing and receive outcomes.
   assumes one clock domain and the synchronous active-low rstn. */
module rfa_addr_filter_checker (
  input wire logic clock,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic rx_valid,
  input wire logic rx_is_ack,
  input wire logic rx_forward,
  input wire logic rx_discard,
  input wire logic ack_send,
  input wire logic ack_skip_backoff,
  input wire logic tx_accept,
  input wire logic tx_go,
  input wire logic buffer_empty_line,
  input wire logic exception_line
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // receive outcome follows each checked packet
  skip_backoff_a: assert property (ack_send |-> ack_skip_backoff)
    else $error("ack without backoff skip");
  fwd_excl_a: assert property (!(rx_forward && rx_discard))
    else $error("forward and discard together");
  rx_answer_a: assert property (rx_valid && !rx_is_ack
    |-> ##[1:2] (rx_forward || rx_discard)) else $error("rx not answered");
  ack_with_rx_a: assert property (ack_send
    |-> (rx_forward || rx_discard)) else $error("ack without outcome");
  fwd_cause_a: assert property (rx_forward
    |-> ($past(rx_valid) || $past(rx_valid, 2))) else $error("stray forward");
  // transmit side: request holds, empty line low while sending
  go_hold_a: assert property (tx_go && !tx_accept |=> tx_go)
    else $error("tx_go dropped early");
  busy_empty_a: assert property (tx_go |-> !buffer_empty_line)
    else $error("empty while sending");
  exc_sticky_a: assert property (exception_line
    && !(psel && penable && pwrite) |=> exception_line)
    else $error("exception cleared alone");
  cover property (rx_forward);
  cover property (ack_send && rx_discard);
  cover property ($rose(exception_line));
endmodule
bind rfa_addr_filter rfa_addr_filter_checker chk_u (.clock, .rstn, .psel,
  .penable, .pwrite, .rx_valid, .rx_is_ack, .rx_forward, .rx_discard,
  .ack_send, .ack_skip_backoff, .tx_accept, .tx_go, .buffer_empty_line,
  .exception_line);

/* File: tb/rfa_radio_model.sv */
/* radio core stand-in on the transmit side: takes each tx_go packet.
   assumes tx_go holds until tx_accept; slow picks a long airtime. */
module rfa_radio_model (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic slow,
  input  wire logic tx_go,
  output logic      tx_accept
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_cnt;
  // one-cycle accept pulse; restart so a retry counts again
  always_ff @(posedge clock)
  begin
    if (!rstn || !tx_go || tx_accept)
    begin
      wait_cnt  <= 4'h0;
      tx_accept <= 1'b0;
    end
    else
    begin
      wait_cnt  <= wait_cnt + 4'h1;
      tx_accept <= (wait_cnt == (slow ? 4'h6 : 4'h1));
    end
  end
endmodule

/* File: tb/tb_rfa_addr_filter.sv */
/* self-checking bench for rfa_addr_filter over apb and header ports.
   assumes rfa_radio_model on the tx side and a short ack wait. */
module tb_rfa_addr_filter;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] SN = 32'h2468_ace0; // arbitrary value
  localparam logic [15:0] CC = 16'h3c3c;      // arbitrary value
  logic        clock, rstn, psel, penable, pwrite, rx_valid, rx_ack_req;
  logic        rx_is_ack, tx_request, tx_accept, slow, pready, pslverr, e;
  logic        rx_forward, rx_discard, ack_send, tx_go, tx_ack_req;
  logic        tx_cust_en, buffer_empty_line, exception_line;
  logic [2:0]  rx_type, tx_type, res;
  logic [7:0]  paddr, rx_seq, tx_seq;
  logic [15:0] tx_cust;
  logic [31:0] pwdata, prdata, rx_src, rx_dst, tx_src, tx_dst, r, ack_dst;
  int          failures = 0;
  int          samples_checked = 0;
  int          i;
  rfa_addr_filter #(.OWN_SERIAL(SN), .CUST_CODE(CC), .ACK_WAIT_CYC(20)) dut_u (
    .clock, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rx_valid, .rx_type, .rx_ack_req, .rx_is_ack, .rx_src,
    .rx_dst, .rx_seq, .rx_forward, .rx_discard, .ack_send,
    .ack_skip_backoff(), .ack_type(), .ack_dst, .ack_seq(), .tx_request,
    .tx_queue_empty(1'b1), .tx_accept, .tx_go, .tx_type, .tx_ack_req, .tx_src,
    .tx_dst, .tx_cust_en, .tx_cust, .tx_seq, .buffer_empty_line,
    .exception_line);
  rfa_radio_model radio_u (.clock, .rstn, .slow, .tx_go, .tx_accept);
  initial
  begin
    clock = 0;
    forever #4 clock = ~clock;
  end
  task complete_run;
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [63:0] g, input logic [63:0] x);
    samples_checked++;
    if (g !== x)
    begin
      failures++;
      $display("Error at %0t: got %0h expected %0h", $time, g, x);
    end
  endtask
  // request holds until pready is seen; data and error taken at that edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    e = pslverr;
    r = prdata;
    {psel, penable} <= 2'b00;
    @(posedge clock);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  // one header, then gather {forward, discard, ack} over four cycles
  task rxc(input logic [2:0] t, input logic [1:0] ak, input logic [31:0] s,
           input logic [31:0] d, input logic [7:0] q, input logic [2:0] x);
    @(posedge clock);
    {rx_valid, rx_type, rx_ack_req, rx_is_ack} <= {1'b1, t, ak};
    {rx_src, rx_dst, rx_seq} <= {s, d, q};
    @(posedge clock);
    rx_valid <= 1'b0;
    res = 3'h0;
    repeat (4)
    begin
      @(posedge clock);
      #1 res = res | {rx_forward, rx_discard, ack_send};
    end
    chk(res, x);
  endtask
  task go;
    @(posedge clock);
    tx_request <= 1'b1;
    @(posedge clock);
    tx_request <= 1'b0;
  endtask
  initial
  begin
    {psel, penable, pwrite, rx_valid, rx_ack_req, rx_is_ack} = 6'h0;
    {tx_request, slow, rstn, paddr, rx_type, rx_seq} = 22'h0;
    {pwdata, rx_src, rx_dst} = 96'h0;
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    rd(8'h00, 32'h06);
    rd(8'h04, 32'h02);
    rd(8'h18, 32'hffff_ffff);
    rd(8'h1c, SN);
    chk({buffer_empty_line, exception_line}, 2'b10);
    rd(8'h40, 32'h0);
    chk(e, 1'b1);
    $display("registers done");
    rxc(3'h4, 2'b00, 32'h1, SN, 8'h01, 3'b100);
    rxc(3'h4, 2'b00, 32'h1, SN ^ 32'h1, 8'h02, 3'b010);
    wr(8'h14, 32'h0000_1234);
    wr(8'h18, 32'h0);
    wr(8'h08, 32'h2);
    rxc(3'h6, 2'b10, 32'haaaa_0001, 32'h1234, 8'h05, 3'b101);
    chk(ack_dst, 32'haaaa_0001);
    rxc(3'h6, 2'b10, 32'haaaa_0001, 32'h1234, 8'h05, 3'b011);
    rd(8'h10, 32'haaaa_0001);
    wr(8'h18, 32'hff);
    rxc(3'h6, 2'b10, 32'haaaa_0002, 32'h12ff, 8'h06, 3'b100);
    wr(8'h04, 32'h3);
    wr(8'h14, 32'h1234_5678);
    wr(8'h18, 32'h000f_ffff);
    rxc(3'h7, 2'b00, 32'h3, 32'h123a_bcde, 8'h07, 3'b100);
    rxc(3'h7, 2'b00, 32'h3, 32'h223a_bcde, 8'h08, 3'b010);
    $display("receive done");
    wr(8'h00, 32'h04);
    wr(8'h0c, 32'hbeef);
    chk({tx_src, tx_dst}, {SN, 32'hbeef});
    wr(8'h00, 32'h16);
    wr(8'h10, 32'h5678);
    wr(8'h20, 32'h1);
    chk({tx_type, tx_ack_req, tx_cust_en, tx_cust, tx_dst[15:0]},
        {3'h6, 2'b11, CC, 16'h5678});
    go;
    for (i = 0; i < 2000 && exception_line !== 1'b1; i++) @(posedge clock);
    chk(exception_line, 1'b1);
    wr(8'h24, 32'h2);
    chk(exception_line, 1'b0);
    slow <= 1'b1;
    go;
    for (i = 0; i < 200 && tx_accept !== 1'b1; i++) @(posedge clock);
    rxc(3'h6, 2'b01, 32'h5678, 32'h1234, tx_seq, 3'b000);
    chk({buffer_empty_line, exception_line}, 2'b10);
    $display("transmit done");
    complete_run;
  end
  // tests need a few hundred cycles; the 12500-cycle limit cuts a hang short
  initial
  begin
    #100000;
    failures++;
    complete_run;
  end
endmodule
